// [common/timer_defines.vh]
// Behaviour
// - power-reduce bit set keeps timer disabled
// - counter and compare registers 8 bits
// - flags visible; mask gates each request
// - clock select zero stops the counter
// - async select picks oscillator clock source
// - compares run every cycle continuously
// - compare match sets channel flag
// - bottom flagged when counter becomes 0x00
// - max recognised when counter becomes 0xff
// - top is 0xff or compare a
// - each tick clears, increments or decrements
// - cpu reads/writes counter anytime
// - cpu counter write beats count/clear
// - 3-bit mode split over control a/b
// - overflow flag point depends on mode
// - outputs top and bottom indications
// - match results go to waveform outputs
// - normal mode wraps, overflow at zero
// - clear-on-compare mode clears at compare a
// - match flag set one tick after equality
// - counter write blocks next tick's match
`ifndef TIMER_DEFINES_VH
`define TIMER_DEFINES_VH
// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define ADDR_COUNT 12'h000
`define ADDR_CMP_A 12'h004
`define ADDR_CMP_B 12'h008
`define ADDR_CTRL_A 12'h00c
`define ADDR_CTRL_B 12'h010
`define ADDR_FLAGS 12'h014
`define ADDR_MASK 12'h018
`define ADDR_ASYNC 12'h01c
`define ADDR_POWER 12'h020
// ----------------------------------------
// field positions and values
// ----------------------------------------
`define FLAG_OVF 0
`define FLAG_CMPA 1
`define FLAG_CMPB 2
`define CTRLB_MODE2 3
`define ASYNC_SEL 5
`define POWER_TIM 6
`define MODE_NORMAL 3'h0
`define MODE_PC_FF 3'h1
`define MODE_CLEAR_CMP 3'h2
`define MODE_FAST_FF 3'h3
`define MODE_PC_OCA 3'h5
`define MODE_FAST_OCA 3'h7
`define CNT_MAX 8'hff
`define CNT_BOTTOM 8'h00
`define POWER_RESET 8'h00
`endif

// [src/timer_counter_unit.v]
// Register access over APB and the register offsets were decided locally.
`include "timer_defines.vh"

module timer_counter_unit (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire osc_pin_in,
  output reg irq_overflow,
  output reg irq_compare_a,
  output reg irq_compare_b,
  output reg compare_match_a,
  output reg compare_match_b,
  output reg top_ind,
  output reg bottom_ind,
  output reg max_ind,
  output reg timer_enabled
);

  // ----------------------------------------
  // registers
  // ----------------------------------------
  reg [7:0] timer_count_value;
  reg [7:0] compare_value_a;
  reg [7:0] compare_value_b;
  reg [7:0] timer_control_a;
  reg [7:0] timer_control_b;
  reg [2:0] timer_flag_register;
  reg [2:0] timer_mask_register;
  reg [7:0] async_status_register;
  reg [7:0] power_reduction_register;
  reg [9:0] prescale;
  reg osc_sync1;
  reg osc_sync2;
  reg osc_prev;
  reg count_down;
  reg block_match;

  wire [2:0] clock_select_field = timer_control_b[2:0];
  wire waveform_mode_bit0 = timer_control_a[0];
  wire waveform_mode_bit1 = timer_control_a[1];
  wire waveform_mode_bit2 = timer_control_b[`CTRLB_MODE2];
  // mode split over two control registers
  wire [2:0] waveform_mode_field = {waveform_mode_bit2, waveform_mode_bit1, waveform_mode_bit0};
  wire async_clock_select = async_status_register[`ASYNC_SEL];
  wire power_off = power_reduction_register[`POWER_TIM];

  // one select per register, shared by every write process below
  wire hit_count = (paddr == `ADDR_COUNT);
  wire hit_cmp_a = (paddr == `ADDR_CMP_A);
  wire hit_cmp_b = (paddr == `ADDR_CMP_B);
  wire hit_ctrl_a = (paddr == `ADDR_CTRL_A);
  wire hit_ctrl_b = (paddr == `ADDR_CTRL_B);
  wire hit_flags = (paddr == `ADDR_FLAGS);
  wire hit_mask = (paddr == `ADDR_MASK);
  wire hit_async = (paddr == `ADDR_ASYNC);
  wire hit_power = (paddr == `ADDR_POWER);

  // writes land only in the access phase, the edge the master samples pready
  wire access = psel & penable;
  wire wr = access & pwrite;
  wire wr_count = wr & hit_count;
  wire wr_flags = wr & hit_flags;

  // ----------------------------------------
  // clock select and timer tick
  // ----------------------------------------
  // oscillator pin crosses two flops before the edge detector
  // detector resets low; a pin that idles high gives one stray edge after reset
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_sync1 <= 1'b0;
      osc_sync2 <= 1'b0;
      osc_prev <= 1'b0;
    end else begin
      osc_sync1 <= osc_pin_in;
      osc_sync2 <= osc_sync1;
      osc_prev <= osc_sync2;
    end
  end

  // free-running divider; it is not cleared on a select change, so the
  // first slow tick after a change may come early
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      prescale <= 10'h000;
    else
      prescale <= prescale + 10'h001;
  end

  wire src_edge = async_clock_select ? (osc_sync2 & ~osc_prev) : 1'b1;
  reg src_tick;
  // prescale taps; the divide table is a simple stand-in
  always @* begin
    src_tick = 1'b0;
    case (clock_select_field)
      3'h0: src_tick = 1'b0; // stopped
      3'h1: src_tick = 1'b1;
      3'h2: src_tick = (prescale[2:0] == 3'h0);
      3'h3: src_tick = (prescale[4:0] == 5'h00);
      3'h4: src_tick = (prescale[5:0] == 6'h00);
      3'h5: src_tick = (prescale[6:0] == 7'h00);
      3'h6: src_tick = (prescale[7:0] == 8'h00);
      default: src_tick = (prescale == 10'h000);
    endcase
  end
  // power-reduce bit gates the whole tick
  wire tick = src_edge & src_tick & ~power_off;

  // ----------------------------------------
  // counter control
  // ----------------------------------------
  wire top_is_cmp = (waveform_mode_field == `MODE_CLEAR_CMP) |
                    (waveform_mode_field == `MODE_PC_OCA) |
                    (waveform_mode_field == `MODE_FAST_OCA);
  wire [7:0] top_value = top_is_cmp ? compare_value_a : `CNT_MAX;
  wire phase_correct = (waveform_mode_field == `MODE_PC_FF) |
                       (waveform_mode_field == `MODE_PC_OCA);
  wire at_top = (timer_count_value == top_value);
  wire at_bottom = (timer_count_value == `CNT_BOTTOM);
  // equality evaluated every pclk, not only at ticks
  wire eq_a = (timer_count_value == compare_value_a);
  wire eq_b = (timer_count_value == compare_value_b);

  reg [7:0] next_count;
  reg next_down;
  reg ovf_event;
  // one action per tick: clear, up or down
  always @* begin
    next_count = timer_count_value;
    next_down = count_down;
    ovf_event = 1'b0;
    if (phase_correct) begin
      if (count_down) begin
        next_count = timer_count_value - 8'h01;
        if (timer_count_value == 8'h01 || at_bottom) begin
          next_down = 1'b0;
          ovf_event = 1'b1; // overflow at bottom in dual slope
        end
      end else begin
        next_count = timer_count_value + 8'h01;
        if (at_top || timer_count_value == (top_value - 8'h01))
          next_down = 1'b1;
        if (at_top)
          next_count = timer_count_value - 8'h01;
      end
    end else if (at_top) begin
      next_count = `CNT_BOTTOM; // clear / wrap
      next_down = 1'b0;
      // clear-on-compare flags only a true 0xff wrap, other single slope modes at top
      if (waveform_mode_field == `MODE_CLEAR_CMP)
        ovf_event = (timer_count_value == `CNT_MAX);
      else
        ovf_event = 1'b1;
    end else begin
      next_count = timer_count_value + 8'h01;
      next_down = 1'b0;
      // a count left above a lowered top still wraps through 0xff
      ovf_event = (timer_count_value == `CNT_MAX);
    end
  end

  // counter write wins over tick; reset zeros state
  // a write leaves the direction alone, so a dual slope count keeps its way
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_count_value <= 8'h00;
      count_down <= 1'b0;
    end else if (wr_count) begin
      timer_count_value <= pwdata[7:0];
    end else if (tick) begin
      timer_count_value <= next_count;
      count_down <= next_down;
    end
  end

  // counter write blocks a match at the next tick, even when stopped
  // the block outlives a stopped clock and ends only at the next tick
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      block_match <= 1'b0;
    else if (wr_count)
      block_match <= 1'b1;
    else if (tick)
      block_match <= 1'b0;
  end

  // ----------------------------------------
  // compare and overflow events
  // ----------------------------------------
  // a matching tick is dropped while the write block stands
  wire match_a = tick & eq_a & ~block_match;
  wire match_b = tick & eq_b & ~block_match;
  wire ovf_set = tick & ~wr_count & ovf_event;

  // ----------------------------------------
  // flags: set beats write-one-to-clear
  // ----------------------------------------
  wire [2:0] flag_set = {match_b, match_a, ovf_set};
  wire [2:0] flag_clr = wr_flags ? pwdata[2:0] : 3'h0;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      timer_flag_register <= 3'h0;
    else
      timer_flag_register <= (timer_flag_register & ~flag_clr) | flag_set;
  end

  // ----------------------------------------
  // apb register writes
  // ----------------------------------------
  // compares are written straight through: no double buffer here
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      compare_value_a <= 8'h00;
    else if (wr & hit_cmp_a)
      compare_value_a <= pwdata[7:0];
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      compare_value_b <= 8'h00;
    else if (wr & hit_cmp_b)
      compare_value_b <= pwdata[7:0];
  end

  // mode low bits live here, mode bit 2 in control b
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      timer_control_a <= 8'h00;
    else if (wr & hit_ctrl_a)
      timer_control_a <= pwdata[7:0];
  end

  // clock select in the low bits; zero stops the count
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      timer_control_b <= 8'h00;
    else if (wr & hit_ctrl_b)
      timer_control_b <= pwdata[7:0];
  end

  // one mask bit per flag, same bit order as the flags
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      timer_mask_register <= 3'h0;
    else if (wr & hit_mask)
      timer_mask_register <= pwdata[2:0];
  end

  // a source switch is not glitch-filtered; stop the timer before changing it
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      async_status_register <= 8'h00;
    else if (wr & hit_async)
      async_status_register <= pwdata[7:0];
  end

  // resets to zero, so the timer is enabled out of reset; clock select zero still holds the count
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      power_reduction_register <= `POWER_RESET;
    else if (wr & hit_power)
      power_reduction_register <= pwdata[7:0];
  end

  // ----------------------------------------
  // apb read and response
  // ----------------------------------------
  reg [31:0] next_rdata;
  reg next_err;
  always @* begin
    next_rdata = 32'h00000000;
    next_err = 1'b0;
    if (paddr == `ADDR_COUNT)
      next_rdata = {24'h000000, timer_count_value};
    else if (paddr == `ADDR_CMP_A)
      next_rdata = {24'h000000, compare_value_a};
    else if (paddr == `ADDR_CMP_B)
      next_rdata = {24'h000000, compare_value_b};
    else if (paddr == `ADDR_CTRL_A)
      next_rdata = {24'h000000, timer_control_a};
    else if (paddr == `ADDR_CTRL_B)
      next_rdata = {24'h000000, timer_control_b};
    else if (paddr == `ADDR_FLAGS)
      next_rdata = {29'h00000000, timer_flag_register};
    else if (paddr == `ADDR_MASK)
      next_rdata = {29'h00000000, timer_mask_register};
    else if (paddr == `ADDR_ASYNC)
      next_rdata = {24'h000000, async_status_register};
    else if (paddr == `ADDR_POWER)
      next_rdata = {24'h000000, power_reduction_register};
    else
      next_err = 1'b1;
  end

  // no wait state although pready comes straight from a flop: the answer is
  // prepared in the setup cycle and stands for the single access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (psel & ~penable) begin
      pready <= 1'b1;
      pslverr <= next_err;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // read data is captured at setup and holds until the next setup;
  // a count read shows the value before any tick in the access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      prdata <= 32'h00000000;
    else if (psel & ~penable)
      prdata <= next_rdata;
  end

  // ----------------------------------------
  // interrupt requests
  // ----------------------------------------
  // level requests from flag and mask; they fall when software clears the flag or its mask bit
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_overflow <= 1'b0;
      irq_compare_a <= 1'b0;
      irq_compare_b <= 1'b0;
    end else begin
      irq_overflow <= timer_flag_register[`FLAG_OVF] & timer_mask_register[`FLAG_OVF];
      irq_compare_a <= timer_flag_register[`FLAG_CMPA] & timer_mask_register[`FLAG_CMPA];
      irq_compare_b <= timer_flag_register[`FLAG_CMPB] & timer_mask_register[`FLAG_CMPB];
    end
  end

  // ----------------------------------------
  // waveform generator feeds
  // ----------------------------------------
  // one pclk pulse per matching tick, a cycle after the compare
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compare_match_a <= 1'b0;
      compare_match_b <= 1'b0;
    end else begin
      compare_match_a <= match_a; // to waveform generator
      compare_match_b <= match_b;
    end
  end

  // count levels trail the counter by one pclk
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      top_ind <= 1'b0;
      bottom_ind <= 1'b0;
      max_ind <= 1'b0;
    end else begin
      top_ind <= at_top;
      bottom_ind <= at_bottom;
      max_ind <= (timer_count_value == `CNT_MAX);
    end
  end

  // ----------------------------------------
  // module enable
  // ----------------------------------------
  // shows the power-reduce gate to the rest of the chip
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      timer_enabled <= 1'b0;
    else
      timer_enabled <= ~power_off;
  end

endmodule

// [test/timer_counter_unit_checker.sv]
module timer_counter_unit_checker (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire pready,
  input wire pslverr,
  input wire irq_overflow,
  input wire irq_compare_a,
  input wire compare_match_a,
  input wire bottom_ind,
  input wire max_ind,
  input wire timer_enabled
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // -----------------------------
  // recent causes
  // -----------------------------
  // the overflow irq may only fall after a bus write; compare a irq may only rise after a write or a match seen lately
  reg [2:0] wr_hist;
  reg [2:0] ma_hist;
  wire wr_acc = psel && penable && pwrite;
  wire cause_a = |{wr_hist, ma_hist, compare_match_a};
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_hist <= 3'h0;
      ma_hist <= 3'h0;
    end else begin
      wr_hist <= {wr_hist[1:0], wr_acc};
      ma_hist <= {ma_hist[1:0], compare_match_a};
    end
  end
  // -----------------------------
  // properties
  // -----------------------------
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_error_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_bottom_max_apart: assert property (!(bottom_ind && max_ind))
    else $error("bottom and max together");
  a_power_quiet: assert property (!timer_enabled [*2] |-> !compare_match_a)
    else $error("match while powered down");
  a_enable_by_write: assert property ($fell(timer_enabled) |-> |wr_hist)
    else $error("disable without write");
  a_ovf_irq_clear: assert property ($fell(irq_overflow) |-> |wr_hist)
    else $error("overflow irq dropped alone");
  a_cmpa_irq_cause: assert property ($rose(irq_compare_a) |-> cause_a)
    else $error("compare irq without match");
  c_match: cover property (compare_match_a);
  c_ovf: cover property ($rose(irq_overflow));
  c_err: cover property (pslverr);
endmodule
bind timer_counter_unit timer_counter_unit_checker u_timer_counter_unit_checker (
  .pclk, .presetn, .psel, .penable, .pwrite, .pready, .pslverr, .irq_overflow,
  .irq_compare_a, .compare_match_a, .bottom_ind, .max_ind, .timer_enabled);

// [test/test_async_8bit_timer_counter_unit.sv]
`include "timer_defines.vh"
module test_async_8bit_timer_counter_unit;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, osc_pin_in, pready, pslverr, err, pm;
  logic irq_overflow, irq_compare_a, irq_compare_b, compare_match_a, compare_match_b;
  logic top_ind, bottom_ind, max_ind, timer_enabled, sa, sb;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  int fail_count, cmp_count, cyc, n;
  timer_counter_unit u_timer_counter_unit (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .osc_pin_in, .irq_overflow,
    .irq_compare_a, .irq_compare_b, .compare_match_a, .compare_match_b, .top_ind,
    .bottom_ind, .max_ind, .timer_enabled);
  // -----------------------------
  // clock, hang guard, helpers
  // -----------------------------
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // a stuck handshake must still reach the verdict
  always @(posedge pclk) begin
    cyc++;
    if (cyc > 20000) begin
      fail_count++;
      $display("ERROR %0t timeout", $time);
      summarize;
    end
  end
  task summarize;
    $display("checks %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // request held until pready is sampled high at an edge
  task xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask
  task rdc(input logic [11:0] a, input logic [31:0] exp);
    xfer(a, 1'b0, 32'h0);
    check(rd, exp);
  endtask
  // -----------------------------
  // scenarios
  // -----------------------------
  task test_reset;
    // registered outputs settle one edge after reset is released
    repeat (2) @(posedge pclk);
    check({31'h0, bottom_ind}, 32'h1);
    check({31'h0, timer_enabled}, 32'h1);
    rdc(`ADDR_COUNT, 32'h0);
    rdc(`ADDR_CMP_A, 32'h0);
    rdc(`ADDR_CMP_B, 32'h0);
    rdc(`ADDR_FLAGS, 32'h0);
    rdc(`ADDR_MASK, 32'h0);
    wr(12'h100, 32'h5);
    check({31'h0, err}, 32'h1);
    rdc(12'h100, 32'h0);
    $display("test_reset done");
  endtask
  task test_rw;
    wr(`ADDR_COUNT, 32'h1a5);
    wr(`ADDR_CMP_A, 32'hf3c);
    wr(`ADDR_CMP_B, 32'h2c3);
    repeat (20) @(posedge pclk);
    rdc(`ADDR_COUNT, 32'ha5);
    rdc(`ADDR_CMP_A, 32'h3c);
    rdc(`ADDR_CMP_B, 32'hc3);
    $display("test_rw done");
  endtask
  task test_normal;
    wr(`ADDR_MASK, 32'h7);
    wr(`ADDR_COUNT, 32'hf0);
    wr(`ADDR_CTRL_B, 32'h1);
    n = 0;
    while (bottom_ind !== 1'b1 && n < 100) begin
      pm = max_ind;
      @(posedge pclk);
      n++;
    end
    check({31'h0, irq_overflow}, 32'h1);
    check({31'h0, pm}, 32'h1);
    wr(`ADDR_CTRL_B, 32'h0);
    rdc(`ADDR_FLAGS, 32'h1);
    wr(`ADDR_MASK, 32'h0);
    repeat (3) @(posedge pclk);
    check({31'h0, irq_overflow}, 32'h0);
    wr(`ADDR_FLAGS, 32'h1);
    rdc(`ADDR_FLAGS, 32'h0);
    $display("test_normal done");
  endtask
  // the written value equals compare b, so the first tick must not match
  task test_block;
    wr(`ADDR_CMP_B, 32'h20);
    wr(`ADDR_CMP_A, 32'h24);
    wr(`ADDR_COUNT, 32'h20);
    wr(`ADDR_MASK, 32'h7);
    wr(`ADDR_CTRL_B, 32'h1);
    sa = 1'b0;
    sb = 1'b0;
    repeat (12) begin
      @(posedge pclk);
      sa = sa | (compare_match_a === 1'b1);
      sb = sb | (compare_match_b === 1'b1);
    end
    wr(`ADDR_CTRL_B, 32'h0);
    check({31'h0, sb}, 32'h0);
    check({31'h0, sa}, 32'h1);
    rdc(`ADDR_FLAGS, 32'h2);
    check({30'h0, irq_compare_b, irq_compare_a}, 32'h1);
    wr(`ADDR_FLAGS, 32'h7);
    $display("test_block done");
  endtask
  task test_clear_cmp;
    wr(`ADDR_CTRL_A, {29'h0, `MODE_CLEAR_CMP});
    wr(`ADDR_CMP_A, 32'h5);
    wr(`ADDR_COUNT, 32'h0);
    wr(`ADDR_CTRL_B, 32'h1);
    n = 0;
    while (compare_match_a !== 1'b1 && n < 50) begin
      @(posedge pclk);
      n++;
    end
    check({31'h0, top_ind}, 32'h1);
    check({31'h0, max_ind}, 32'h0);
    @(posedge pclk);
    n = 1;
    while (compare_match_a !== 1'b1 && n < 50) begin
      @(posedge pclk);
      n++;
    end
    check(32'(n), 32'h6);
    wr(`ADDR_CTRL_B, 32'h0);
    wr(`ADDR_CTRL_A, 32'h0);
    $display("test_clear_cmp done");
  endtask
  task test_power;
    wr(`ADDR_COUNT, 32'h10);
    wr(`ADDR_POWER, 32'h40);
    wr(`ADDR_CTRL_B, 32'h1);
    check({31'h0, timer_enabled}, 32'h0);
    repeat (20) @(posedge pclk);
    wr(`ADDR_CTRL_B, 32'h0);
    rdc(`ADDR_COUNT, 32'h10);
    wr(`ADDR_POWER, 32'h0);
    $display("test_power done");
  endtask
  // the count may only move on oscillator edges once the source is switched
  task test_async;
    wr(`ADDR_COUNT, 32'h0);
    wr(`ADDR_ASYNC, 32'h20);
    wr(`ADDR_CTRL_B, 32'h1);
    repeat (5) begin
      repeat (4) @(posedge pclk);
      osc_pin_in <= 1'b1;
      repeat (4) @(posedge pclk);
      osc_pin_in <= 1'b0;
    end
    repeat (6) @(posedge pclk);
    wr(`ADDR_CTRL_B, 32'h0);
    rdc(`ADDR_COUNT, 32'h5);
    $display("test_async done");
  endtask
  initial begin
    {psel, penable, pwrite, osc_pin_in, presetn} = 5'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    test_reset;
    test_rw;
    test_normal;
    test_block;
    test_clear_cmp;
    test_power;
    test_async;
    summarize;
  end
endmodule
